// ---- rtl/apr_pkg.sv ----
package apr_pkg;
    typedef logic [15:0] apr_word_t;
    typedef logic [2:0]  apr_test_t;

    localparam logic [4:0] REG_EXP  = 5'h06;
    localparam logic [4:0] REG_NPTX = 5'h07;
    localparam logic [4:0] REG_LPNP = 5'h08;
    localparam logic [4:0] REG_GCTL = 5'h09;

    localparam int EXP_PDF    = 4;
    localparam int EXP_LPNP   = 3;
    localparam int EXP_NPCAP  = 2;
    localparam int EXP_PRX    = 1;
    localparam int EXP_LPAN   = 0;
    localparam int NP_MORE    = 15;
    localparam int NP_MSG     = 13;
    localparam int NP_ACK2    = 12;
    localparam int NP_TOG     = 11;
    localparam int GC_TEST_HI = 15;
    localparam int GC_TEST_LO = 13;
    localparam int GC_MSMAN   = 12;
    localparam int GC_MSVAL   = 11;
    localparam int GC_PORT    = 10;
    localparam int GC_ADVFD   = 9;
    localparam int GC_ADVHD   = 8;

    localparam logic        NP_MSG_RST  = 1'b1;
    localparam logic [10:0] NP_CODE_RST = 11'h3ff;
    localparam logic        NP_CAP_RST  = 1'b1;
    localparam apr_test_t   GC_TEST_RST = 3'h0;

    localparam apr_test_t TEST_NORMAL = 3'h0;
    localparam apr_test_t TEST_WAVE   = 3'h1;
    localparam apr_test_t TEST_MJIT   = 3'h2;
    localparam apr_test_t TEST_SJIT   = 3'h3;
    localparam apr_test_t TEST_DIST   = 3'h4;

    localparam logic [5:0] PRE_LEN   = 6'h20;
    localparam logic [3:0] OP_LAST   = 4'h1;
    localparam logic [3:0] ADR_LAST  = 4'h9;
    localparam logic [3:0] DATA_LAST = 4'hf;
    localparam logic [1:0] OP_READ   = 2'b10;
    localparam logic [1:0] OP_WRITE  = 2'b01;
endpackage

// ---- rtl/apr_mdio_if.sv ----
`timescale 1ns/1ps
interface apr_mdio_if;
    logic mdc_rise;
    logic mdio_bit;
    modport sync (output mdc_rise, output mdio_bit);
    modport core (input mdc_rise, input mdio_bit);
endinterface

// ---- rtl/apr_mdio_sync.sv ----
`timescale 1ns/1ps
module apr_mdio_sync (
    input  wire logic clk_i,
    input  wire logic rst_i,
    input  wire logic mdc_i,
    input  wire logic mdio_i,
    apr_mdio_if.sync  mif
);
    import apr_pkg::*;

    typedef struct packed {
        logic mdc_s1;
        logic mdc_s2;
        logic mdc_d;
        logic dio_s1;
        logic dio_s2;
    } apr_sync_t;

    apr_sync_t st;
    apr_sync_t next_st;

    always_comb begin
        next_st        = st;
        next_st.mdc_s1 = mdc_i;
        next_st.mdc_s2 = st.mdc_s1;
        next_st.mdc_d  = st.mdc_s2;
        next_st.dio_s1 = mdio_i;
        next_st.dio_s2 = st.dio_s1;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            // ones, so a pin idling high gives no false edge after reset
            st <= '1;
        end else begin
            st <= next_st;
        end
    end

    // one-cycle pulse per management clock rising edge
    assign mif.mdc_rise = st.mdc_s2 & ~st.mdc_d;
    assign mif.mdio_bit = st.dio_s2;
endmodule

// ---- rtl/apr_regs.sv ----
`timescale 1ns/1ps
// How it works
// [RULE1] expansion bits 15:5 always read zero
// [RULE2] parallel detection fault latches high
// [RULE3] bit 3 shows partner next-page ability
// [RULE4] local next-page capability, resets one, latching
// [RULE5] page received latches until read
// [RULE6] bit 0 shows partner autoneg ability
// [RULE7] host sets more-pages bit, resets zero
// [RULE8] message page bit writable, resets one
// [RULE9] comply bit writable, resets zero
// [RULE10] toggle reads inverse of last sent
// [RULE11] message code writable, resets 0x3ff
// [RULE12] partner page captured read-only, resets zero
// [RULE13] test mode select, reserved codes act normal
// [RULE14] bit 12 forces manual master/slave
// [RULE15] master value ignored unless manual
// [RULE16] port type sets automatic role preference
// [RULE17] bit 9 advertises gigabit full duplex
// [RULE18] bit 8 advertises gigabit half duplex
// [RULE19] host writes zero to bits 7:0
// [RULE20] bits 12:8 extend advertised ability field
// [RULE21] latched bits clear on read unless persisting
module apr_regs #(
    parameter logic [4:0] PHY_ADDR     = 5'h01,
    parameter bit         LOCAL_NP_CAP = 1'b1
) (
    input  wire logic          CLOCK_I,
    input  wire logic          RST_I,
    input  wire logic          MDC_I,
    input  wire logic          MDIO_I,
    output logic               MDIO_O,
    output logic               MDIO_OE_O,
    input  wire logic          PD_FAULT_I,
    input  wire logic          LP_NP_ABLE_I,
    input  wire logic          LP_AN_ABLE_I,
    input  wire logic          PAGE_RX_I,
    input  apr_pkg::apr_word_t LP_PAGE_I,
    input  wire logic          LAST_TX_TOGGLE_I,
    output apr_pkg::apr_word_t TX_PAGE_O,
    output logic               TX_PAGE_LOAD_O,
    output apr_pkg::apr_test_t TEST_MODE_O,
    output logic               MS_MANUAL_O,
    output logic               MS_MASTER_O,
    output logic               PREFER_MASTER_O,
    output logic               ADV_1000FD_O,
    output logic               ADV_1000HD_O,
    output logic [4:0]         TECH_EXT_O
);
    import apr_pkg::*;

    typedef enum logic [2:0] {
        S_IDLE,
        S_ST,
        S_OP,
        S_ADR,
        S_TA,
        S_DATA
    } apr_mstate_t;

    typedef struct packed {
        apr_mstate_t ms;
        logic [5:0]  pre;
        logic [3:0]  cnt;
        logic [1:0]  op;
        logic [9:0]  adr;
        apr_word_t   sh;
        logic        mdio_o;
        logic        mdio_oe;
        logic        pd_fault;
        logic        np_cap;
        logic        page_rx;
        logic        np_more;
        logic        np_msg;
        logic        np_ack2;
        logic [10:0] np_code;
        logic        toggle;
        logic        np_load;
        apr_word_t   lp_page;
        apr_test_t   test_sel;
        apr_test_t   test_act;
        logic        ms_man;
        logic        ms_val;
        logic        port_type;
        logic        adv_fd;
        logic        adv_hd;
    } apr_state_t;

    apr_mdio_if mif ();

    apr_mdio_sync u_sync (
        .clk_i  (CLOCK_I),
        .rst_i  (RST_I),
        .mdc_i  (MDC_I),
        .mdio_i (MDIO_I),
        .mif    (mif)
    );

    apr_state_t st;
    apr_state_t next_st;
    logic [9:0] full_adr;
    apr_word_t  rd_word;
    apr_word_t  wdata;
    logic       cap_rd;
    logic       clr_exp;
    logic       commit;
    logic       rd_drive;

    function automatic apr_state_t reset_state();
        apr_state_t s;
        s         = '0;
        s.ms      = S_IDLE;
        s.np_cap  = NP_CAP_RST;
        s.np_msg  = NP_MSG_RST;
        s.np_code = NP_CODE_RST;
        s.test_sel = GC_TEST_RST;
        s.test_act = GC_TEST_RST;
        return s;
    endfunction

    function automatic apr_word_t read_word(input logic [4:0] a, input apr_state_t s,
                                            input logic lpnp, input logic lpan);
        apr_word_t w;
        w = '0;
        case (a)
            REG_EXP:  w = {11'h000, s.pd_fault, lpnp,                    // [RULE1] [RULE3]
                           s.np_cap, s.page_rx, lpan};                   // [RULE6]
            REG_NPTX: w = {s.np_more, 1'b0, s.np_msg, s.np_ack2, s.toggle, s.np_code};
            REG_LPNP: w = s.lp_page;
            REG_GCTL: w = {s.test_sel, s.ms_man, s.ms_val, s.port_type,
                           s.adv_fd, s.adv_hd, 8'h00};
            default:  w = '0;
        endcase
        return w;
    endfunction

    // reserved test codes leave the transmitter in normal operation
    function automatic apr_test_t test_effective(input apr_test_t sel);
        apr_test_t t;
        t = (sel > TEST_DIST) ? TEST_NORMAL : sel;
        return t;
    endfunction

    assign full_adr = {st.adr[8:0], mif.mdio_bit};
    assign rd_word  = read_word(full_adr[4:0], st, LP_NP_ABLE_I, LP_AN_ABLE_I);
    assign wdata    = {st.sh[14:0], mif.mdio_bit};
    assign cap_rd   = mif.mdc_rise && (st.ms == S_ADR) && (st.cnt == ADR_LAST)
                      && (st.op == OP_READ) && (full_adr[9:5] == PHY_ADDR);
    assign clr_exp  = cap_rd && (full_adr[4:0] == REG_EXP);
    assign rd_drive = (st.op == OP_READ) && (st.adr[9:5] == PHY_ADDR);
    assign commit   = mif.mdc_rise && (st.ms == S_DATA) && (st.cnt == DATA_LAST)
                      && (st.op == OP_WRITE) && (st.adr[9:5] == PHY_ADDR);

    always_comb begin
        next_st         = st;
        next_st.np_load = 1'b0;
        next_st.toggle  = ~LAST_TX_TOGGLE_I;                             // [RULE10]
        // a new event in the read cycle survives the clear
        next_st.pd_fault = (st.pd_fault & ~clr_exp) | PD_FAULT_I;        // [RULE2]
        next_st.page_rx  = (st.page_rx & ~clr_exp) | PAGE_RX_I;          // [RULE5]
        next_st.np_cap   = (st.np_cap & ~clr_exp) | LOCAL_NP_CAP;        // [RULE4]
        if (PAGE_RX_I) begin
            next_st.lp_page = LP_PAGE_I;                                 // [RULE12]
        end
        if (commit) begin
            case (st.adr[4:0])
                REG_NPTX: begin
                    next_st.np_more = wdata[NP_MORE];                    // [RULE7]
                    next_st.np_msg  = wdata[NP_MSG];                     // [RULE8]
                    next_st.np_ack2 = wdata[NP_ACK2];                    // [RULE9]
                    next_st.np_code = wdata[10:0];                       // [RULE11]
                    next_st.np_load = 1'b1;
                end
                REG_GCTL: begin
                    next_st.test_sel  = wdata[GC_TEST_HI:GC_TEST_LO];    // [RULE13]
                    next_st.ms_man    = wdata[GC_MSMAN];                 // [RULE14]
                    next_st.ms_val    = wdata[GC_MSVAL];                 // [RULE15]
                    next_st.port_type = wdata[GC_PORT];                  // [RULE16]
                    next_st.adv_fd    = wdata[GC_ADVFD];                 // [RULE17]
                    next_st.adv_hd    = wdata[GC_ADVHD];                 // [RULE18]
                end
                default: begin
                end
            endcase
        end
        next_st.test_act = test_effective(st.test_sel);                  // [RULE13]
        if (mif.mdc_rise) begin
            unique case (st.ms)
                S_IDLE: begin
                    if (mif.mdio_bit) begin
                        if (st.pre != PRE_LEN) begin
                            next_st.pre = st.pre + 6'h01;
                        end
                    end else begin
                        if (st.pre == PRE_LEN) begin
                            next_st.ms = S_ST;
                        end
                        next_st.pre = '0;
                    end
                end
                S_ST: begin
                    next_st.ms  = mif.mdio_bit ? S_OP : S_IDLE;
                    next_st.cnt = '0;
                end
                S_OP: begin
                    next_st.op  = {st.op[0], mif.mdio_bit};
                    next_st.cnt = st.cnt + 4'h1;
                    if (st.cnt == OP_LAST) begin
                        next_st.cnt = '0;
                        if (({st.op[0], mif.mdio_bit} == OP_READ) ||
                            ({st.op[0], mif.mdio_bit} == OP_WRITE)) begin
                            next_st.ms = S_ADR;
                        end else begin
                            next_st.ms = S_IDLE;
                        end
                    end
                end
                S_ADR: begin
                    next_st.adr = full_adr;
                    next_st.cnt = st.cnt + 4'h1;
                    if (st.cnt == ADR_LAST) begin
                        next_st.ms  = S_TA;
                        next_st.cnt = '0;
                        if (cap_rd) begin
                            next_st.sh = rd_word;                        // [RULE21]
                        end
                    end
                end
                S_TA: begin
                    if (st.cnt == '0) begin
                        next_st.cnt = 4'h1;
                        if (rd_drive) begin
                            next_st.mdio_oe = 1'b1;
                            next_st.mdio_o  = 1'b0;
                        end
                    end else begin
                        next_st.ms  = S_DATA;
                        next_st.cnt = '0;
                        if (rd_drive) begin
                            next_st.mdio_o = st.sh[15];
                            next_st.sh     = {st.sh[14:0], 1'b0};
                        end
                    end
                end
                S_DATA: begin
                    next_st.cnt = st.cnt + 4'h1;
                    if (st.op == OP_WRITE) begin
                        next_st.sh = wdata;
                    end
                    if (st.cnt == DATA_LAST) begin
                        next_st.ms      = S_IDLE;
                        next_st.cnt     = '0;
                        next_st.mdio_oe = 1'b0;
                        next_st.mdio_o  = 1'b0;
                    end else if (rd_drive) begin
                        next_st.mdio_o = st.sh[15];
                        next_st.sh     = {st.sh[14:0], 1'b0};
                    end
                end
                default: begin
                    next_st.ms = S_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge CLOCK_I) begin
        if (RST_I) begin
            st <= reset_state();
        end else begin
            st <= next_st;
        end
    end

    assign MDIO_O          = st.mdio_o;
    assign MDIO_OE_O       = st.mdio_oe;
    assign TX_PAGE_O       = {st.np_more, 1'b0, st.np_msg, st.np_ack2, st.toggle, st.np_code};
    assign TX_PAGE_LOAD_O  = st.np_load;
    assign TEST_MODE_O     = st.test_act;
    assign MS_MANUAL_O     = st.ms_man;                                  // [RULE14]
    assign MS_MASTER_O     = st.ms_man & st.ms_val;                      // [RULE15]
    assign PREFER_MASTER_O = ~st.ms_man & st.port_type;                  // [RULE16]
    assign ADV_1000FD_O    = st.adv_fd;                                  // [RULE17]
    assign ADV_1000HD_O    = st.adv_hd;                                  // [RULE18]
    assign TECH_EXT_O      = {st.ms_man, st.ms_val, st.port_type, st.adv_fd, st.adv_hd}; // [RULE20]

    property p_exp_rsv;
        @(posedge CLOCK_I) disable iff (RST_I) clr_exp |=> st.sh[15:5] == 11'h000;
    endproperty
    a_exp_rsv: assert property (p_exp_rsv) else $error("reserved bits not zero"); // [RULE1]

    property p_pdf;
        @(posedge CLOCK_I) disable iff (RST_I)
            (PD_FAULT_I || (st.pd_fault && !clr_exp)) |=> st.pd_fault;
    endproperty
    a_pdf: assert property (p_pdf) else $error("fault not latched"); // [RULE2]

    property p_lpnp;
        @(posedge CLOCK_I) disable iff (RST_I)
            clr_exp |=> st.sh[EXP_LPNP] == $past(LP_NP_ABLE_I);
    endproperty
    a_lpnp: assert property (p_lpnp) else $error("partner np ability wrong"); // [RULE3]

    property p_npcap;
        @(posedge CLOCK_I) disable iff (RST_I) clr_exp |=> st.sh[EXP_NPCAP] == LOCAL_NP_CAP;
    endproperty
    a_npcap: assert property (p_npcap) else $error("np capability wrong"); // [RULE4]

    property p_prx;
        @(posedge CLOCK_I) disable iff (RST_I)
            PAGE_RX_I ##1 !clr_exp |=> st.page_rx;
    endproperty
    a_prx: assert property (p_prx) else $error("page received lost"); // [RULE5]

    property p_lpan;
        @(posedge CLOCK_I) disable iff (RST_I)
            clr_exp |=> st.sh[EXP_LPAN] == $past(LP_AN_ABLE_I);
    endproperty
    a_lpan: assert property (p_lpan) else $error("partner an ability wrong"); // [RULE6]

    property p_toggle;
        @(posedge CLOCK_I) disable iff (RST_I)
            !$past(RST_I) |-> TX_PAGE_O[NP_TOG] == !$past(LAST_TX_TOGGLE_I);
    endproperty
    a_toggle: assert property (p_toggle) else $error("toggle not inverted"); // [RULE10]

    property p_npw;
        @(posedge CLOCK_I) disable iff (RST_I) commit && (st.adr[4:0] == REG_NPTX)
            |=> TX_PAGE_LOAD_O && ((TX_PAGE_O & 16'hb7ff) == ($past(wdata) & 16'hb7ff));
    endproperty
    a_npw: assert property (p_npw) else $error("next page write lost"); // [RULE11]

    property p_lppg;
        @(posedge CLOCK_I) disable iff (RST_I) PAGE_RX_I |=> st.lp_page == $past(LP_PAGE_I);
    endproperty
    a_lppg: assert property (p_lppg) else $error("partner page not captured"); // [RULE12]

    property p_test;
        @(posedge CLOCK_I) disable iff (RST_I)
            (st.test_sel > TEST_DIST) |=> TEST_MODE_O == TEST_NORMAL;
    endproperty
    a_test: assert property (p_test) else $error("reserved test mode applied"); // [RULE13]

    property p_msman;
        @(posedge CLOCK_I) disable iff (RST_I) MS_MASTER_O |-> MS_MANUAL_O;
    endproperty
    a_msman: assert property (p_msman) else $error("master forced without manual"); // [RULE15]

    property p_tech;
        @(posedge CLOCK_I) disable iff (RST_I) commit && (st.adr[4:0] == REG_GCTL)
            |=> {3'h0, TECH_EXT_O, 8'h00} == ($past(wdata) & 16'h1f00);
    endproperty
    a_tech: assert property (p_tech) else $error("ability extension wrong"); // [RULE20]

    property p_lhclr;
        @(posedge CLOCK_I) disable iff (RST_I) clr_exp && !PAGE_RX_I
            |=> !st.page_rx && (st.sh[EXP_PRX] == $past(st.page_rx));
    endproperty
    a_lhclr: assert property (p_lhclr) else $error("latched bit not cleared"); // [RULE21]
endmodule

// ---- tb/apr_host_model.sv ----
`timescale 1ns/1ps
module apr_host_model (
    input  wire logic clk_i,
    input  wire logic dev_oe_i,
    input  wire logic dev_bit_i,
    output logic      mdc_o,
    output logic      mdio_o,
    output logic      host_oe_o
);
    import apr_pkg::*;
    logic host_bit;

    initial begin
        mdc_o     = 1'b0;
        host_oe_o = 1'b0;
        host_bit  = 1'b1;
    end

    // pulled up, so a released line reads one
    assign mdio_o = dev_oe_i ? dev_bit_i : (host_oe_o ? host_bit : 1'b1);

    // data changes while the clock is low and is sampled as it rises
    task automatic shift(input logic oe, input logic b, output logic s);
        @(posedge clk_i);
        mdc_o     <= 1'b0;
        host_oe_o <= oe;
        host_bit  <= b;
        repeat (4) @(posedge clk_i);
        s = mdio_o;
        mdc_o <= 1'b1;
        repeat (3) @(posedge clk_i);
    endtask

    task automatic frame(input logic [1:0] op, input logic [4:0] adr, input logic [4:0] rg,
                         input apr_word_t wd, output apr_word_t rd, output logic ta);
        logic [13:0] hdr;
        logic        drv;
        logic        s;
        hdr = {2'b01, op, adr, rg};
        drv = (op == OP_WRITE);
        for (int i = 0; i < 32; i++) shift(1'b1, 1'b1, s);
        for (int i = 13; i >= 0; i--) shift(1'b1, hdr[i], s);
        shift(drv, 1'b1, s);
        shift(drv, 1'b0, ta);
        for (int i = 15; i >= 0; i--) begin
            shift(drv, wd[i], s);
            rd[i] = s;
        end
        shift(1'b0, 1'b1, s);
    endtask
endmodule

// ---- tb/autoneg_page_regs_test.sv ----
`timescale 1ns/1ps
module autoneg_page_regs_test;
    import apr_pkg::*;

    typedef struct packed {
        logic [4:0] rg;
        apr_word_t  wd;
        apr_word_t  rd;
        apr_word_t  ex;
    } apr_row_t;

    localparam logic [4:0] PHY_A  = 5'h01;
    localparam int         N_ROWS = 20;
    // register, value written, value read back, outputs expected
    localparam apr_row_t ROWS [N_ROWS] = '{
        '{5'h06, 16'hffff, 16'h000d, 16'h0000},
        '{5'h08, 16'hffff, 16'h0000, 16'h0000},
        '{5'h0a, 16'hffff, 16'h0000, 16'h0000},
        '{5'h07, 16'hffff, 16'hb7ff, 16'hb7ff},
        '{5'h07, 16'h0000, 16'h0000, 16'h0000},
        '{5'h07, 16'h8555, 16'h8555, 16'h8555},
        '{5'h09, 16'h2000, 16'h2000, 16'h0400},
        '{5'h09, 16'h4000, 16'h4000, 16'h0800},
        '{5'h09, 16'h6000, 16'h6000, 16'h0c00},
        '{5'h09, 16'h8000, 16'h8000, 16'h1000},
        '{5'h09, 16'ha000, 16'ha000, 16'h0000},
        '{5'h09, 16'hc000, 16'hc000, 16'h0000},
        '{5'h09, 16'he000, 16'he000, 16'h0000},
        '{5'h09, 16'h1800, 16'h1800, 16'h0318},
        '{5'h09, 16'h0800, 16'h0800, 16'h0008},
        '{5'h09, 16'h0400, 16'h0400, 16'h0084},
        '{5'h09, 16'h1400, 16'h1400, 16'h0214},
        '{5'h09, 16'h0200, 16'h0200, 16'h0042},
        '{5'h09, 16'h0100, 16'h0100, 16'h0021},
        '{5'h09, 16'h02ff, 16'h0200, 16'h0042}
    };

    logic       clk;
    logic       rst;
    logic       mdc;
    logic       mdio;
    logic       dev_bit;
    logic       dev_oe;
    logic       host_oe;
    logic       pd_fault;
    logic       lp_np;
    logic       lp_an;
    logic       page_rx;
    apr_word_t  lp_page;
    logic       last_tog;
    apr_word_t  tx_page;
    logic       tx_load;
    apr_test_t  test_mode;
    logic       ms_manual;
    logic       ms_master;
    logic       prefer_master;
    logic       adv_fd;
    logic       adv_hd;
    logic [4:0] tech_ext;
    apr_word_t  gig;
    apr_word_t  got;
    apr_row_t   r;
    logic       t;
    int         err_total;
    int         n_checks;
    int         loads;
    int         fights;
    int         c0;

    apr_regs #(.PHY_ADDR(PHY_A), .LOCAL_NP_CAP(1'b1)) i_dut (
        .CLOCK_I(clk), .RST_I(rst), .MDC_I(mdc), .MDIO_I(mdio), .MDIO_O(dev_bit),
        .MDIO_OE_O(dev_oe), .PD_FAULT_I(pd_fault), .LP_NP_ABLE_I(lp_np),
        .LP_AN_ABLE_I(lp_an), .PAGE_RX_I(page_rx), .LP_PAGE_I(lp_page),
        .LAST_TX_TOGGLE_I(last_tog), .TX_PAGE_O(tx_page), .TX_PAGE_LOAD_O(tx_load),
        .TEST_MODE_O(test_mode), .MS_MANUAL_O(ms_manual), .MS_MASTER_O(ms_master),
        .PREFER_MASTER_O(prefer_master), .ADV_1000FD_O(adv_fd), .ADV_1000HD_O(adv_hd),
        .TECH_EXT_O(tech_ext)
    );

    apr_host_model i_host (
        .clk_i(clk), .dev_oe_i(dev_oe), .dev_bit_i(dev_bit), .mdc_o(mdc), .mdio_o(mdio),
        .host_oe_o(host_oe)
    );

    assign gig = {3'h0, test_mode, ms_manual, ms_master, prefer_master, adv_fd, adv_hd, tech_ext};

    always #10 clk = ~clk;

    always @(posedge clk) begin
        if (tx_load === 1'b1) loads <= loads + 1;
        if (dev_oe === 1'b1 && host_oe === 1'b1) fights <= fights + 1;
    end

    task automatic check(input apr_word_t seen, input apr_word_t exp);
        n_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr_reg(input logic [4:0] rg, input apr_word_t d);
        apr_word_t x;
        logic      ta;
        i_host.frame(OP_WRITE, PHY_A, rg, d, x, ta);
    endtask

    // a silent device leaves the turnaround bit at the pulled-up level
    task automatic rd_reg(input logic [4:0] a, input logic [4:0] rg, output apr_word_t d);
        logic ta;
        i_host.frame(OP_READ, a, rg, 16'h0000, d, ta);
        check({15'h0, ta}, {15'h0, a != PHY_A});
    endtask

    task automatic stop_test;
        $display("checks %0d errors %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    initial begin
        clk = 1'b0;
        rst = 1'b1;
        pd_fault = 1'b0;
        lp_np = 1'b1;
        lp_an = 1'b1;
        page_rx = 1'b0;
        lp_page = 16'h0000;
        last_tog = 1'b1;
        err_total = 0;
        n_checks = 0;
        loads = 0;
        fights = 0;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        for (int i = 0; i < N_ROWS; i++) begin
            r = ROWS[i];
            c0 = loads;
            wr_reg(r.rg, r.wd);
            rd_reg(PHY_A, r.rg, got);
            check(got, r.rd);
            check(16'(loads - c0), {15'h0, r.rg == REG_NPTX});
            if (r.rg == REG_GCTL) check(gig, r.ex);
            if (r.rg == REG_NPTX) check(tx_page, r.ex);
        end
        @(posedge clk);
        lp_page  <= 16'hf123;
        page_rx  <= 1'b1;
        pd_fault <= 1'b1;
        lp_np    <= 1'b0;
        @(posedge clk);
        page_rx  <= 1'b0;
        pd_fault <= 1'b0;
        lp_page  <= 16'h0000;
        rd_reg(PHY_A, REG_LPNP, got);
        check(got, 16'hf123);
        rd_reg(PHY_A, REG_EXP, got);
        check(got, 16'h0017);
        lp_an <= 1'b0;
        rd_reg(PHY_A, REG_EXP, got);
        check(got, 16'h0004);
        pd_fault <= 1'b1;
        rd_reg(PHY_A, REG_EXP, got);
        check(got, 16'h0014);
        pd_fault <= 1'b0;
        rd_reg(PHY_A, REG_EXP, got);
        check(got, 16'h0014);
        rd_reg(PHY_A, REG_EXP, got);
        check(got, 16'h0004);
        last_tog <= 1'b0;
        rd_reg(PHY_A, REG_NPTX, got);
        check(got, 16'h8d55);
        check(tx_page, 16'h8d55);
        rd_reg(5'h02, REG_GCTL, got);
        check(got, 16'hffff);
        i_host.frame(OP_WRITE, 5'h02, REG_GCTL, 16'h1f00, got, t);
        i_host.frame(2'b11, PHY_A, REG_GCTL, 16'h1f00, got, t);
        rd_reg(PHY_A, REG_GCTL, got);
        check(got, 16'h0200);
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        check(tx_page, 16'h23ff);
        check(gig, 16'h0000);
        rst <= 1'b0;
        rd_reg(PHY_A, REG_NPTX, got);
        check(got, 16'h2bff);
        rd_reg(PHY_A, REG_LPNP, got);
        check(got, 16'h0000);
        rd_reg(PHY_A, REG_GCTL, got);
        check(got, 16'h0000);
        rd_reg(PHY_A, REG_EXP, got);
        check(got, 16'h0004);
        check(16'(fights), 16'h0000);
        stop_test();
    end
endmodule
